// ==== common/fws_regs.vh ====
// Constants for the flash write-status polling controller.
`ifndef FWS_REGS_VH
`define FWS_REGS_VH
// Register offsets on the software port.
`define FWS_ADDR_CTRL 4'h0
`define FWS_ADDR_ADDR 4'h1
`define FWS_ADDR_DATA 4'h2
`define FWS_ADDR_STAT 4'h3
`define FWS_ADDR_RDAT 4'h4
// Control register fields.
`define FWS_CTRL_START 0
`define FWS_CTRL_MODE 1
`define FWS_CTRL_ABORT 2
// Status register fields.
`define FWS_STAT_BUSY 0
`define FWS_STAT_DONE 1
`define FWS_STAT_FAIL 2
`define FWS_STAT_SUSP 3
`define FWS_STAT_RDY 4
`define FWS_STAT_ERWIN 5
// Status bit positions in the data byte.
`define FWS_POLL_BIT 7
`define FWS_TOGGLE_BIT 6
`define FWS_TMO_BIT 5
`define FWS_ERWIN_BIT 3
`define FWS_SECT_BIT 2
// Reset command written to the device.
`define FWS_RESET_CMD 8'hF0
// Flash bus cycle timing (read, write pulse, gap), in ns, and cycles at 4 ns.
`define FWS_CLK_NS 4
`define FWS_TRD_NS 70
`define FWS_TRD_CYC ((`FWS_TRD_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_TWP_NS 40
`define FWS_TWP_CYC ((`FWS_TWP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_TGAP_NS 20
`define FWS_TGAP_CYC ((`FWS_TGAP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`endif

// ==== hw/fws_bus_cycle.v ====
// One flash bus cycle engine: a timed read or write on the parallel pins.
`timescale 1ns/1ns
`include "fws_regs.vh"
module fws_bus_cycle (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Request side
   input wire req,
   input wire wr,
   input wire [19:0] addr,
   input wire [7:0] wdata,
   output reg ack_q,
   output reg [7:0] rdata_q,
   // Flash pins
   output reg [19:0] fl_addr_q,
   output reg fl_ce_n_q,
   output reg fl_oe_n_q,
   output reg fl_we_n_q,
   output reg [7:0] fl_dq_o_q,
   output reg fl_dq_oe_n_q,
   input wire [7:0] fl_dq_s
);
   localparam ST_IDLE = 2'h0;
   localparam ST_ACT = 2'h1;
   localparam ST_GAP = 2'h2;
   // Two extra read cycles cover the data synchroniser.
   localparam [31:0] RD_CYC = `FWS_TRD_CYC + 2;
   localparam [31:0] WP_CYC = `FWS_TWP_CYC;
   localparam [31:0] GAP_CYC = `FWS_TGAP_CYC;
   reg [1:0] st_q;
   reg [7:0] cnt_q;
   reg wr_q;
   always @(posedge sys_clk) begin
      ack_q <= 1'b0;
      if (reset) begin
         st_q <= ST_IDLE;
         cnt_q <= 8'h00;
         wr_q <= 1'b0;
         rdata_q <= 8'h00;
         fl_addr_q <= 20'h00000;
         fl_ce_n_q <= 1'b1;
         fl_oe_n_q <= 1'b1;
         fl_we_n_q <= 1'b1;
         fl_dq_o_q <= 8'h00;
         fl_dq_oe_n_q <= 1'b1;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (req) begin
                  wr_q <= wr;
                  fl_addr_q <= addr;
                  fl_ce_n_q <= 1'b0;
                  fl_oe_n_q <= wr;
                  fl_we_n_q <= ~wr;
                  fl_dq_o_q <= wdata;
                  fl_dq_oe_n_q <= ~wr;
                  cnt_q <= wr ? WP_CYC[7:0] : RD_CYC[7:0];
                  st_q <= ST_ACT;
               end
            end
            ST_ACT: begin
               if (cnt_q == 8'h00) begin
                  // Read data is sampled after the synchroniser delay.
                  if (!wr_q)
                     rdata_q <= fl_dq_s;
                  fl_ce_n_q <= 1'b1;
                  fl_oe_n_q <= 1'b1;
                  fl_we_n_q <= 1'b1;
                  cnt_q <= GAP_CYC[7:0];
                  st_q <= ST_GAP;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            ST_GAP: begin
               fl_dq_oe_n_q <= 1'b1;
               if (cnt_q == 8'h00) begin
                  ack_q <= 1'b1;
                  st_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
endmodule

// ==== hw/fws_poll_ctrl.v ====
// Host-side controller that polls flash write status after program or erase.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "fws_regs.vh"
module fws_poll_ctrl (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Software register port
   input wire [3:0] sw_addr,
   input wire [31:0] sw_wdata,
   input wire sw_wr,
   input wire sw_rd,
   output reg [31:0] sw_rdata_q,
   // Flash pins
   output wire [19:0] fl_addr,
   output wire fl_ce_n,
   output wire fl_oe_n,
   output wire fl_we_n,
   output wire [7:0] fl_dq_o,
   output wire fl_dq_oe_n,
   input wire [7:0] fl_dq_i,
   input wire ready_busy_out
);
   localparam ST_IDLE = 3'h0;
   localparam ST_RD1 = 3'h1;
   localparam ST_RD2 = 3'h2;
   localparam ST_RD3 = 3'h3;
   localparam ST_RD4 = 3'h4;
   localparam ST_RST = 3'h5;
   localparam ST_DATA = 3'h6;

   reg [7:0] dq_m_q;
   reg [7:0] dq_s_q;
   reg rb_m_q;
   reg rb_s_q;
   reg [2:0] st_q;
   reg mode_q;
   reg [19:0] addr_q;
   reg [7:0] data_q;
   reg [7:0] first_q;
   reg [7:0] last_q;
   reg [7:0] rdat_q;
   reg busy_q;
   reg done_q;
   reg fail_q;
   reg susp_q;
   reg erwin_q;
   reg req_q;
   reg wr_q;
   wire ack;
   wire [7:0] rdata;
   reg [7:0] stat_d;

   // Two-stage synchronisers for the pins.
   always @(posedge sys_clk) begin
      if (reset) begin
         dq_m_q <= 8'h00;
         dq_s_q <= 8'h00;
         rb_m_q <= 1'b1;
         rb_s_q <= 1'b1;
      end else begin
         dq_m_q <= fl_dq_i;
         dq_s_q <= dq_m_q;
         rb_m_q <= ready_busy_out;
         rb_s_q <= rb_m_q;
      end
   end

   fws_bus_cycle u_cyc (
      .sys_clk(sys_clk),
      .reset(reset),
      .req(req_q),
      .wr(wr_q),
      .addr(addr_q),
      .wdata(`FWS_RESET_CMD),
      .ack_q(ack),
      .rdata_q(rdata),
      .fl_addr_q(fl_addr),
      .fl_ce_n_q(fl_ce_n),
      .fl_oe_n_q(fl_oe_n),
      .fl_we_n_q(fl_we_n),
      .fl_dq_o_q(fl_dq_o),
      .fl_dq_oe_n_q(fl_dq_oe_n),
      .fl_dq_s(dq_s_q)
   );

   // True when toggle bit 6 differs between two reads.
   function toggled;
      input [7:0] a;
      input [7:0] b;
      begin
         toggled = (a[`FWS_TOGGLE_BIT] != b[`FWS_TOGGLE_BIT]);
      end
   endfunction

   // Data polling is done when bit 7 equals expected true data, or when bit 7 is 1 for an erase.
   function poll_done;
      input [7:0] v;
      input erase;
      input [7:0] exp;
      begin
         if (erase)
            poll_done = v[`FWS_POLL_BIT];
         else
            poll_done = (v[`FWS_POLL_BIT] == exp[`FWS_POLL_BIT]);
      end
   endfunction

   // One request pulse to the cycle engine per read or reset write.
   always @(posedge sys_clk) begin
      req_q <= 1'b0;
      if (reset) begin
         st_q <= ST_IDLE;
         mode_q <= 1'b0;
         addr_q <= 20'h00000;
         data_q <= 8'h00;
         first_q <= 8'h00;
         last_q <= 8'h00;
         rdat_q <= 8'h00;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         susp_q <= 1'b0;
         erwin_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         if (sw_wr && sw_addr == `FWS_ADDR_ADDR)
            addr_q <= sw_wdata[19:0];
         if (sw_wr && sw_addr == `FWS_ADDR_DATA)
            data_q <= sw_wdata[7:0];
         if (sw_wr && sw_addr == `FWS_ADDR_CTRL &&
             sw_wdata[`FWS_CTRL_ABORT]) begin
            // Abandoned polling must begin again from the first read.
            st_q <= ST_IDLE;
            busy_q <= 1'b0;
         end else begin
            case (st_q)
               ST_IDLE: begin
                  // Software starts only after it issued the final strobe.
                  if (sw_wr && sw_addr == `FWS_ADDR_CTRL &&
                      sw_wdata[`FWS_CTRL_START]) begin
                     mode_q <= sw_wdata[`FWS_CTRL_MODE];
                     busy_q <= 1'b1;
                     done_q <= 1'b0;
                     fail_q <= 1'b0;
                     susp_q <= 1'b0;
                     wr_q <= 1'b0;
                     req_q <= 1'b1;
                     st_q <= ST_RD1;
                  end
               end
               ST_RD1: begin
                  if (ack) begin
                     first_q <= rdata;
                     req_q <= 1'b1;
                     st_q <= ST_RD2;
                  end
               end
               ST_RD2: begin
                  if (ack) begin
                     last_q <= rdata;
                     erwin_q <= rdata[`FWS_ERWIN_BIT];
                     if (!toggled(first_q, rdata) ||
                         (!mode_q && poll_done(rdata, mode_q, data_q))) begin
                        // Bit 7 may lead bits 6..0; fetch clean data.
                        req_q <= 1'b1;
                        st_q <= ST_DATA;
                     end else if (mode_q && poll_done(rdata, 1'b1, data_q) &&
                                  !toggled(first_q, rdata)) begin
                        st_q <= ST_DATA;
                     end else if (rdata[`FWS_TMO_BIT]) begin
                        req_q <= 1'b1;
                        st_q <= ST_RD3;
                     end else begin
                        // Keep monitoring: bit 6 still toggling and bit 5 clear.
                        first_q <= rdata;
                        req_q <= 1'b1;
                        st_q <= ST_RD2;
                     end
                  end
               end
               ST_RD3: begin
                  if (ack) begin
                     first_q <= rdata;
                     req_q <= 1'b1;
                     st_q <= ST_RD4;
                  end
               end
               ST_RD4: begin
                  if (ack) begin
                     if (toggled(first_q, rdata)) begin
                        fail_q <= 1'b1;
                        wr_q <= 1'b1;
                        req_q <= 1'b1;
                        st_q <= ST_RST;
                     end else begin
                        req_q <= 1'b1;
                        st_q <= ST_DATA;
                     end
                  end
               end
               ST_RST: begin
                  if (ack) begin
                     wr_q <= 1'b0;
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                     st_q <= ST_IDLE;
                  end
               end
               ST_DATA: begin
                  if (ack) begin
                     // Bit 2 toggling with bit 6 steady marks suspend.
                     susp_q <= mode_q && rdata[`FWS_POLL_BIT] &&
                        toggled(last_q, rdata) == 1'b0 &&
                        (last_q[`FWS_SECT_BIT] != rdata[`FWS_SECT_BIT]);
                     rdat_q <= rdata;
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                     st_q <= ST_IDLE;
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Status byte; the pin level marks busy while low.
   always @* begin
      stat_d = 8'h00;
      stat_d[`FWS_STAT_BUSY] = busy_q;
      stat_d[`FWS_STAT_DONE] = done_q;
      stat_d[`FWS_STAT_FAIL] = fail_q;
      stat_d[`FWS_STAT_SUSP] = susp_q;
      stat_d[`FWS_STAT_RDY] = rb_s_q;
      stat_d[`FWS_STAT_ERWIN] = erwin_q;
   end

   // Read data stands the cycle after the read strobe.
   always @(posedge sys_clk) begin
      if (reset) begin
         sw_rdata_q <= 32'h00000000;
      end else if (sw_rd) begin
         if (sw_addr == `FWS_ADDR_CTRL)
            sw_rdata_q <= {31'h00000000, busy_q};
         else if (sw_addr == `FWS_ADDR_ADDR)
            sw_rdata_q <= {12'h000, addr_q};
         else if (sw_addr == `FWS_ADDR_DATA)
            sw_rdata_q <= {24'h000000, data_q};
         else if (sw_addr == `FWS_ADDR_STAT)
            sw_rdata_q <= {24'h000000, stat_d};
         else if (sw_addr == `FWS_ADDR_RDAT)
            sw_rdata_q <= {24'h000000, rdat_q};
         else
            sw_rdata_q <= 32'h00000000;
      end
   end
endmodule

// ==== tb/fws_flash_model.sv ====
// Behavioural flash device that answers the status reads of the poller.
`timescale 1ns/1ns
module fws_flash_model (
   // Flash pins
   input wire [19:0] fl_addr,
   input wire fl_ce_n,
   input wire fl_oe_n,
   input wire fl_we_n,
   input wire [7:0] fl_dq_o,
   output reg [7:0] fl_dq_i,
   output wire ready_busy_out,
   // Scenario: op 0 program, 1 erase, 2 stuck, 3 suspended
   input wire arm,
   input wire [1:0] op,
   input wire [7:0] n_reads,
   input wire [7:0] pdata,
   // Observation
   output reg [19:0] last_addr,
   output reg saw_reset
);
   reg busy = 1'h0;
   reg tog = 1'h0;
   reg tog2 = 1'h0;
   reg [7:0] left = 8'h00;
   // Open drain with a pull-up, so suspend leaves the pin high.
   assign ready_busy_out = (busy && op != 2'h3) ? 1'h0 : 1'h1;
   initial begin
      fl_dq_i = 8'h00;
      last_addr = 20'h00000;
      saw_reset = 1'h0;
   end
   always @(posedge arm) begin
      busy = 1'h1;
      left = n_reads;
      saw_reset = 1'h0;
   end
   always @(negedge fl_oe_n) begin
      // Chip select falls in the same time step; let it settle first.
      #1;
      last_addr = fl_addr;
      if (!busy || fl_ce_n) begin
         fl_dq_i = pdata;
      end else begin
         if (op != 2'h3) tog = ~tog;
         if (op[0]) tog2 = ~tog2;
         fl_dq_i = {op == 2'h1 ? 1'h0 : op == 2'h3 ? 1'h1 : ~pdata[7],
            tog, op == 2'h2, 1'h0, op == 2'h1, tog2, 2'h0};
         // A protected target looks the same: a busy span, then array reads.
         if (op < 2'h2) begin
            if (left == 8'h00) begin
               busy = 1'h0;
               // Bit 7 turns true one read before the other bits do.
               fl_dq_i[7] = op[0] | pdata[7];
            end else begin
               left = left - 8'h01;
            end
         end
      end
   end
   // A released bus shows the inverse of the last value, never a copy.
   always @(posedge fl_oe_n) fl_dq_i = ~fl_dq_i;
   always @(posedge fl_we_n) begin
      if (fl_dq_o == 8'hF0) begin
         busy = 1'h0;
         saw_reset = 1'h1;
      end
   end
endmodule

// ==== tb/fws_poll_ctrl_asserts.sv ====
// Checker watching the ports of the flash status poller.
`timescale 1ns/1ns
`include "fws_regs.vh"
module fws_poll_ctrl_asserts (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Software port
   input wire [3:0] sw_addr,
   input wire [31:0] sw_wdata,
   input wire sw_wr,
   input wire sw_rd,
   input wire [31:0] sw_rdata_q,
   // Flash pins
   input wire [19:0] fl_addr,
   input wire fl_ce_n,
   input wire fl_oe_n,
   input wire fl_we_n,
   input wire [7:0] fl_dq_o,
   input wire fl_dq_oe_n,
   input wire [7:0] fl_dq_i,
   input wire ready_busy_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   AST_IDLE_RST: assert property ($fell(reset) |-> fl_ce_n && fl_oe_n &&
      fl_we_n && fl_dq_oe_n) else $error("flash pins not idle after reset");
   AST_START_READ: assert property (sw_wr && sw_addr == `FWS_ADDR_CTRL &&
      sw_wdata[`FWS_CTRL_START] |-> ##[1:4] !fl_oe_n) else $error("no read");
   AST_RD_LEN: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*8])
      else $error("flash read too short");
   AST_OE_GAP: assert property ($rose(fl_oe_n) |-> fl_oe_n [*4])
      else $error("flash reads too close");
   AST_WE_CMD: assert property (!fl_we_n |-> fl_dq_o == `FWS_RESET_CMD &&
      !fl_dq_oe_n && !fl_ce_n && fl_oe_n) else $error("bad flash write");
   AST_WE_LEN: assert property ($fell(fl_we_n) |-> !fl_we_n [*8])
      else $error("write pulse too short");
   AST_ADDR_HOLD: assert property (!fl_oe_n && $past(!fl_oe_n) |->
      $stable(fl_addr)) else $error("address moved in a read");
   AST_UNMAP: assert property (sw_rd && sw_addr > `FWS_ADDR_RDAT |=>
      sw_rdata_q == 32'h0) else $error("unmapped read not zero");
endmodule

// ==== tb/fws_poll_ctrl_bench.sv ====
// Self-checking bench for the flash status poller.
`timescale 1ns/1ns
`include "fws_regs.vh"
module fws_poll_ctrl_bench;
   typedef struct {string nm; logic [31:0] e; logic [31:0] m;} fws_exp_t;
   reg sys_clk = 1'h0;
   reg reset = 1'h1;
   reg [3:0] sw_addr = 4'h0;
   reg [31:0] sw_wdata = 32'h0;
   reg sw_wr = 1'h0;
   reg sw_rd = 1'h0;
   reg chk_rd = 1'h0;
   reg mon_q = 1'h0;
   reg arm = 1'h0;
   reg [1:0] op = 2'h0;
   reg [7:0] n_reads = 8'h02;
   reg [7:0] pdata = 8'h00;
   wire [31:0] sw_rdata_q;
   wire [19:0] fl_addr;
   wire [19:0] last_addr;
   wire fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe_n, ready_busy_out, saw_reset;
   wire [7:0] fl_dq_o;
   wire [7:0] fl_dq_i;
   integer n_errors = 0;
   integer checked = 0;
   integer k;
   fws_exp_t exp_q[$];
   fws_exp_t mx;
   initial forever #2 sys_clk = ~sys_clk;
   fws_poll_ctrl dut (.sys_clk(sys_clk), .reset(reset), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata_q(sw_rdata_q), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
      .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_o(fl_dq_o),
      .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_i(fl_dq_i),
      .ready_busy_out(ready_busy_out));
   fws_flash_model flash (.fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
      .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_o(fl_dq_o),
      .fl_dq_i(fl_dq_i), .ready_busy_out(ready_busy_out), .arm(arm),
      .op(op), .n_reads(n_reads), .pdata(pdata), .last_addr(last_addr),
      .saw_reset(saw_reset));
   task test_done;
      $display("Errors %0d in %0d checks", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked = checked + 1;
      if (g !== e) begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'h1;
      @(posedge sys_clk);
      sw_wr <= 1'h0;
   endtask
   task rd(input [3:0] a, input c, output [31:0] v);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_rd <= 1'h1;
      chk_rd <= c;
      @(posedge sys_clk);
      sw_rd <= 1'h0;
      chk_rd <= 1'h0;
      @(negedge sys_clk);
      v = sw_rdata_q;
   endtask
   // The expectation is queued first; the monitor compares it later.
   task rdc(input string nm, input [3:0] a, input [31:0] e, input [31:0] m);
      fws_exp_t x;
      logic [31:0] v;
      x.nm = nm;
      x.e = e & m;
      x.m = m;
      exp_q.push_back(x);
      rd(a, 1'h1, v);
   endtask
   always @(posedge sys_clk) mon_q <= sw_rd & chk_rd;
   always @(negedge sys_clk) begin
      if (mon_q) begin
         mx = exp_q.pop_front();
         cmp(mx.nm, mx.e, sw_rdata_q & mx.m);
      end
   end
   task run(input [1:0] o, input [7:0] n, input [31:0] st, input [31:0] sm,
      input ab);
      logic [31:0] v;
      logic [19:0] ad;
      logic [7:0] pd;
      integer i;
      ad = $urandom;
      pd = $urandom;
      wr(`FWS_ADDR_ADDR, {12'h0, ad});
      wr(`FWS_ADDR_DATA, {24'h0, pd});
      @(posedge sys_clk);
      op <= o;
      n_reads <= n;
      pdata <= pd;
      arm <= 1'h1;
      @(posedge sys_clk);
      arm <= 1'h0;
      repeat (3) @(posedge sys_clk);
      wr(`FWS_ADDR_CTRL, {30'h0, o[0], 1'h1});
      rdc("busy", `FWS_ADDR_STAT, o == 2'h3 ? 32'h11 : 32'h01, 32'h11);
      if (ab) begin
         // Abandon the poll, let the pending flash cycle drain, restart.
         repeat (10) @(posedge sys_clk);
         wr(`FWS_ADDR_CTRL, 32'h4);
         rdc("abort", `FWS_ADDR_STAT, 32'h0, 32'h01);
         repeat (40) @(posedge sys_clk);
         wr(`FWS_ADDR_CTRL, {30'h0, o[0], 1'h1});
      end
      v = 32'h1;
      for (i = 0; i < 3000 && v[0]; i = i + 1) rd(`FWS_ADDR_STAT, 1'h0, v);
      if (v[0])
         n_errors = n_errors + 1;
      rdc("status", `FWS_ADDR_STAT, st, sm);
      if (o < 2'h2) rdc("data", `FWS_ADDR_RDAT, {24'h0, pd}, 32'hFF);
      if (o < 2'h2) cmp("poll addr", {12'h0, ad}, {12'h0, last_addr});
      if (o == 2'h2) cmp("reset cmd", 32'h1, {31'h0, saw_reset});
   endtask
   initial begin
      void'($urandom(99));
      repeat (16) @(posedge sys_clk);
      reset <= 1'h0;
      rdc("reset stat", `FWS_ADDR_STAT, 32'h10, 32'h1F);
      rdc("unmapped", 4'hF, 32'h0, 32'hFFFFFFFF);
      for (k = 0; k < 3; k = k + 1)
         run(2'h0, 2 + $urandom % 8, 32'h02, 32'h0E, 1'h0);
      run(2'h1, 2 + $urandom % 8, 32'h02, 32'h0E, 1'h0);
      run(2'h3, 8'h02, 32'h08, 32'h0C, 1'h0);
      run(2'h2, 8'h02, 32'h04, 32'h04, 1'h0);
      run(2'h0, 8'h00, 32'h02, 32'h0E, 1'h0);
      run(2'h0, 8'h08, 32'h02, 32'h0E, 1'h1);
      test_done;
   end
   initial begin
      #300000;
      n_errors = n_errors + 1;
      test_done;
   end
endmodule
bind fws_poll_ctrl fws_poll_ctrl_asserts u_chk (.sys_clk(sys_clk),
   .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
   .sw_rd(sw_rd), .sw_rdata_q(sw_rdata_q), .fl_addr(fl_addr),
   .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
   .fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_i(fl_dq_i),
   .ready_busy_out(ready_busy_out));
